/* File: hw/fbr_consts.vh */
`ifndef FBR_CONSTS_VH
`define FBR_CONSTS_VH

// Command codes
`define FBR_CMD_FRAME_SEL 8'hea
`define FBR_CMD_FRAME_DATA 8'heb
`define FBR_CMD_CLEAR 8'hed
`define FBR_CMD_FRAME_NUM 8'hef
`define FBR_CMD_THR 8'hf2
`define FBR_CMD_PHASE 8'hf4
`define FBR_CMD_TIMER 8'hfa

// Fixed answers, reset values, masks and limits
`define FBR_FRAME_COUNT 8'h04
`define FBR_FRAME_BCNT 8'h22
`define FBR_TIMER_BCNT 8'h04
`define FBR_THR_RST 8'h30
`define FBR_PHASE_RST 8'h00
`define FBR_THR_WMASK 8'hfe
`define FBR_PHASE_WMASK 8'hec
`define FBR_DEFAULT_BYTE 8'h00
`define FBR_FRAME_IDENTIFIER_MAX 16'h0003

// Pages
`define FBR_PAGE_CH1 8'h00
`define FBR_PAGE_CH2 8'h01
`define FBR_PAGE_BOTH 8'h81

// Threshold register fields
`define FBR_THR_OV 7
`define FBR_THR_UV 6
`define FBR_THR_PG_HI 5
`define FBR_THR_PG_LO 4
`define FBR_THR_OVR 3
`define FBR_THR_UVR 2
`define FBR_THR_OCR 1
`define FBR_PG_INVALID 2'h1

// Phase control fields
`define FBR_PH_EN 7
`define FBR_PH_HI 6
`define FBR_PH_LO 5
`define FBR_PH_BBOX_DIS 3
`define FBR_PH_VINOV 2

// Frame layout
`define FBR_FIRST_DATA_IDX 6'h03
`define FBR_LAST_DATA_IDX 6'h22
`define FBR_LAST_DATA_OFS 5'h1e
`define FBR_SUM_OFS 5'h1f
`define FBR_CH1_BYTES 18
`define FBR_CH2_BYTES 8
`define FBR_CFG_BYTES 5
`define FBR_NUM_FRAMES 3'h4
`define FBR_FIRST_CYCLIC 2'h1
`define FBR_LAST_SLOT 2'h3
`define FBR_MEM_LAST 7'h7f

`endif

/* File: hw/fbr_frame_store.v */
`timescale 1ns/1ps
`include "fbr_consts.vh"

// Four frames of 32 bytes; one write port, registered read port
module fbr_frame_store (
	input wire i_clk,
	input wire i_we,
	input wire [6:0] i_waddr,
	input wire [7:0] i_wdata,
	input wire [6:0] i_raddr,
	output reg [7:0] o_rdata
);

	reg [7:0] mem [0:127];

	always @(posedge i_clk) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
		o_rdata <= mem[i_raddr];
	end

endmodule // fbr_frame_store

/* File: hw/fbr_recorder.v */
`timescale 1ns/1ps
`include "fbr_consts.vh"

module fbr_recorder (
	input wire i_clk,
	input wire i_nrst,
	input wire [7:0] i_cmd_code,
	input wire [7:0] i_page,
	input wire i_wr_valid,
	input wire [5:0] i_wr_idx,
	input wire [7:0] i_wr_data,
	input wire i_rd_valid,
	input wire [5:0] i_rd_idx,
	output wire [7:0] o_rd_data,
	output reg o_rd_valid,
	input wire [1:0] i_uv_trip,
	input wire i_dual_rail,
	input wire [1:0] i_follower,
	input wire [15:0] i_ch1_status_word,
	input wire [7:0] i_ch1_vout_status,
	input wire [7:0] i_ch1_iout_status,
	input wire [7:0] i_ch1_input_status,
	input wire [7:0] i_ch1_temp_status,
	input wire [15:0] i_ch1_vin,
	input wire [15:0] i_ch1_vout,
	input wire [15:0] i_ch1_iout,
	input wire [15:0] i_temperature,
	input wire [15:0] i_ch2_status_word,
	input wire [7:0] i_ch2_iout_status,
	input wire [7:0] i_ch2_input_status,
	input wire [15:0] i_ch2_vin,
	input wire [15:0] i_ch2_iout,
	input wire [7:0] i_loop_tuning_setting,
	input wire [7:0] i_ch1_current_limit,
	input wire [7:0] i_ch2_current_limit,
	input wire [7:0] i_power_down_enable,
	input wire [2:0] i_ch1_frequency_code,
	input wire [2:0] i_ch2_frequency_code,
	output wire [1:0] o_overvoltage_level_select,
	output wire [1:0] o_undervoltage_level_select,
	output wire [3:0] o_good_output_window_select,
	output wire [1:0] o_overvoltage_response_select,
	output wire [1:0] o_undervoltage_response_select,
	output wire [1:0] o_overcurrent_response_select,
	output wire [1:0] o_protection_active,
	output wire o_overtemp_auto_recovery,
	output wire o_phase_override,
	output wire [1:0] o_phase_select,
	output wire o_input_overvoltage_response_select,
	output wire o_recorder_busy
);

	localparam ST_IDLE = 2'b00;
	localparam ST_WRITE = 2'b01;
	localparam ST_SUM = 2'b10;
	localparam ST_CLEAR = 2'b11;

	reg [7:0] thr_ff [0:1];
	reg [7:0] phase_ff;
	reg [15:0] frame_identifier_ff;
	reg [7:0] frame_identifier_lo_ff;
	reg [31:0] timer_ff;
	reg [1:0] state_ff;
	reg [6:0] addr_ff;
	reg [7:0] sum_ff;
	reg [247:0] snap_ff;
	reg [2:0] used_ff;
	reg [1:0] rot_ff;
	reg [1:0] slot_ff;
	reg [1:0] pend_ff;
	reg clr_pend_ff;
	reg [7:0] rd_data_ff;
	reg rd_mem_ff;
	reg [1:0] trip_meta_ff;
	reg [1:0] trip_sync_ff;
	reg [1:0] trip_old_ff;
	wire [7:0] mem_rdata;
	wire [6:0] mem_raddr;
	wire [7:0] snap_byte;
	wire [7:0] mem_wdata;
	wire mem_we;
	wire rec_en;
	wire [1:0] trip_rise;
	wire wr_clear;
	wire [15:0] frame_identifier_wr;
	wire [1:0] take_rail;
	wire [1:0] thr_hit;
	wire [1:0] next_slot;
	wire [247:0] nxt_snap;
	wire [7:0] byte33;
	wire [5:0] rd_ofs;

	////////////////////////////////////////////////////////////////////////
	// Trip inputs come from the analog side, so they are synchronised first
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : g_trip
			always @(posedge i_clk or negedge i_nrst) begin
				if (!i_nrst) begin
					trip_meta_ff[g] <= 1'b0;
					trip_sync_ff[g] <= 1'b0;
					trip_old_ff[g] <= 1'b0;
				end else begin
					trip_meta_ff[g] <= i_uv_trip[g];
					trip_sync_ff[g] <= trip_meta_ff[g];
					trip_old_ff[g] <= trip_sync_ff[g];
				end
			end
			assign trip_rise[g] = trip_sync_ff[g] & ~trip_old_ff[g];
			assign thr_hit[g] = (i_page == `FBR_PAGE_BOTH) ||
				(i_page == ((g == 0) ? `FBR_PAGE_CH1 : `FBR_PAGE_CH2));
			// Follower keeps its register but the protection stays quiet
			assign o_protection_active[g] = ~i_follower[g];
			assign o_overvoltage_level_select[g] = thr_ff[g][`FBR_THR_OV];
			assign o_undervoltage_level_select[g] = thr_ff[g][`FBR_THR_UV];
			assign o_good_output_window_select[2*g+1:2*g] =
				thr_ff[g][`FBR_THR_PG_HI:`FBR_THR_PG_LO];
			assign o_overvoltage_response_select[g] = thr_ff[g][`FBR_THR_OVR];
			assign o_undervoltage_response_select[g] = thr_ff[g][`FBR_THR_UVR];
			assign o_overcurrent_response_select[g] = thr_ff[g][`FBR_THR_OCR];
		end
	endgenerate
	assign o_overtemp_auto_recovery = 1'b1;
	assign o_phase_override = phase_ff[`FBR_PH_EN];
	assign o_phase_select = phase_ff[`FBR_PH_EN] ? phase_ff[`FBR_PH_HI:`FBR_PH_LO] : 2'h0;
	assign o_input_overvoltage_response_select = phase_ff[`FBR_PH_VINOV];
	assign rec_en = ~phase_ff[`FBR_PH_BBOX_DIS];
	assign o_recorder_busy = (state_ff != ST_IDLE);

	////////////////////////////////////////////////////////////////////////
	// Register writes
	assign wr_clear = i_wr_valid && (i_cmd_code == `FBR_CMD_CLEAR) && (i_wr_idx == 6'h00);
	assign frame_identifier_wr = {i_wr_data, frame_identifier_lo_ff};

	generate
		for (g = 0; g < 2; g = g + 1) begin : g_thr
			always @(posedge i_clk or negedge i_nrst) begin
				if (!i_nrst) begin
					thr_ff[g] <= `FBR_THR_RST;
				end else if (i_wr_valid && (i_cmd_code == `FBR_CMD_THR) && thr_hit[g]) begin
					thr_ff[g][7:6] <= i_wr_data[7:6];
					thr_ff[g][3:1] <= i_wr_data[3:1];
					// Invalid window code would leave no defined pair; keep the old one
					if (i_wr_data[`FBR_THR_PG_HI:`FBR_THR_PG_LO] != `FBR_PG_INVALID) begin
						thr_ff[g][5:4] <= i_wr_data[5:4];
					end
				end
			end
		end
	endgenerate

	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			phase_ff <= `FBR_PHASE_RST;
			frame_identifier_ff <= 16'h0000;
			frame_identifier_lo_ff <= 8'h00;
		end else if (i_wr_valid) begin
			if (i_cmd_code == `FBR_CMD_PHASE) begin
				phase_ff <= i_wr_data & `FBR_PHASE_WMASK;
			end
			if (i_cmd_code == `FBR_CMD_FRAME_SEL) begin
				if (i_wr_idx == 6'h00) begin
					frame_identifier_lo_ff <= i_wr_data;
				end else if ((i_wr_idx == 6'h01) && (frame_identifier_wr <= `FBR_FRAME_IDENTIFIER_MAX)) begin
					frame_identifier_ff <= frame_identifier_wr;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Snapshot of one trip, little-endian, byte 3 in the low bits
	assign take_rail = {2{~i_dual_rail}} | pend_ff;
	assign byte33 = {i_ch1_frequency_code, i_ch2_frequency_code, phase_ff[`FBR_PH_HI:`FBR_PH_LO]};
	assign nxt_snap = {
		byte33, i_power_down_enable, i_ch2_current_limit, i_ch1_current_limit, i_loop_tuning_setting,
		(take_rail[1] ? {i_ch2_iout, i_ch2_vin, i_ch2_input_status, i_ch2_iout_status, i_ch2_status_word}
			: {`FBR_CH2_BYTES{`FBR_DEFAULT_BYTE}}),
		(take_rail[0] ? {i_temperature, i_ch1_iout, i_ch1_vout, i_ch1_vin, i_ch1_temp_status,
			i_ch1_input_status, i_ch1_iout_status, i_ch1_vout_status, i_ch1_status_word, timer_ff}
			: {`FBR_CH1_BYTES{`FBR_DEFAULT_BYTE}})
	};

	assign snap_byte = snap_ff[addr_ff[4:0]*8 +: 8];
	// Frame 0 stays until cleared; afterwards slots 1..3 rotate
	assign next_slot = (used_ff < `FBR_NUM_FRAMES) ? used_ff[1:0] : rot_ff;

	////////////////////////////////////////////////////////////////////////
	// Recording sequencer
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_ff <= ST_IDLE;
			addr_ff <= 7'h00;
			sum_ff <= 8'h00;
			snap_ff <= 248'h0;
			used_ff <= 3'h0;
			rot_ff <= `FBR_FIRST_CYCLIC;
			slot_ff <= 2'h0;
			pend_ff <= 2'h0;
			clr_pend_ff <= 1'b0;
			timer_ff <= 32'h0;
		end else begin
			// Trip arriving while busy waits; set wins over consumption
			pend_ff <= (state_ff == ST_IDLE && pend_ff != 2'h0 && !clr_pend_ff) ?
				(trip_rise & {2{rec_en}}) : (pend_ff | (trip_rise & {2{rec_en}}));
			clr_pend_ff <= (state_ff == ST_IDLE && clr_pend_ff) ? wr_clear : (clr_pend_ff | wr_clear);
			if (i_wr_valid && (i_cmd_code == `FBR_CMD_TIMER) && (i_wr_idx != 6'h00) && (i_wr_idx <= 6'h04)) begin
				timer_ff[{i_wr_idx[1:0] - 2'h1, 3'h0} +: 8] <= i_wr_data;
			end
			case (state_ff)
			ST_IDLE: begin
				addr_ff <= 7'h00;
				sum_ff <= 8'h00;
				if (clr_pend_ff) begin
					state_ff <= ST_CLEAR;
				end else if (pend_ff != 2'h0) begin
					snap_ff <= nxt_snap;
					slot_ff <= next_slot;
					state_ff <= ST_WRITE;
				end
			end
			ST_WRITE: begin
				sum_ff <= sum_ff + snap_byte;
				addr_ff <= addr_ff + 7'h01;
				if (addr_ff[4:0] == `FBR_LAST_DATA_OFS) begin
					state_ff <= ST_SUM;
				end
			end
			ST_SUM: begin
				// Checksum lands only after the whole frame is in place
				state_ff <= ST_IDLE;
				timer_ff <= timer_ff + 32'h1;
				if (used_ff < `FBR_NUM_FRAMES) begin
					used_ff <= used_ff + 3'h1;
				end else begin
					rot_ff <= (rot_ff == `FBR_LAST_SLOT) ? `FBR_FIRST_CYCLIC : rot_ff + 2'h1;
				end
			end
			ST_CLEAR: begin
				addr_ff <= addr_ff + 7'h01;
				used_ff <= 3'h0;
				rot_ff <= `FBR_FIRST_CYCLIC;
				if (addr_ff == `FBR_MEM_LAST) begin
					state_ff <= ST_IDLE;
				end
			end
			default: begin
				state_ff <= ST_IDLE;
			end
			endcase
		end
	end

	assign mem_we = (state_ff != ST_IDLE);
	assign mem_wdata = (state_ff == ST_WRITE) ? snap_byte :
		(state_ff == ST_SUM) ? sum_ff : `FBR_DEFAULT_BYTE;

	////////////////////////////////////////////////////////////////////////
	// Reads: one cycle from request to data
	assign rd_ofs = i_rd_idx - `FBR_FIRST_DATA_IDX;
	assign mem_raddr = {frame_identifier_ff[1:0], rd_ofs[4:0]};

	fbr_frame_store u_store (
		.i_clk(i_clk),
		.i_we(mem_we),
		.i_waddr((state_ff == ST_CLEAR) ? addr_ff :
			{slot_ff, ((state_ff == ST_SUM) ? `FBR_SUM_OFS : addr_ff[4:0])}),
		.i_wdata(mem_wdata),
		.i_raddr(mem_raddr),
		.o_rdata(mem_rdata)
	);

	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rd_data_ff <= 8'h00;
			rd_mem_ff <= 1'b0;
			o_rd_valid <= 1'b0;
		end else begin
			o_rd_valid <= i_rd_valid;
			rd_mem_ff <= 1'b0;
			rd_data_ff <= 8'h00;
			if (i_rd_valid) begin
				case (i_cmd_code)
				`FBR_CMD_FRAME_DATA: begin
					if (i_rd_idx == 6'h00) begin
						rd_data_ff <= `FBR_FRAME_BCNT;
					end else if (i_rd_idx <= 6'h02) begin
						rd_data_ff <= i_rd_idx[1] ? frame_identifier_ff[15:8] : frame_identifier_ff[7:0];
					end else if (i_rd_idx <= `FBR_LAST_DATA_IDX) begin
						rd_mem_ff <= 1'b1;
					end
				end
				`FBR_CMD_FRAME_SEL: rd_data_ff <= i_rd_idx[0] ? frame_identifier_ff[15:8] : frame_identifier_ff[7:0];
				`FBR_CMD_FRAME_NUM: rd_data_ff <= `FBR_FRAME_COUNT;
				`FBR_CMD_THR: rd_data_ff <= ((i_page == `FBR_PAGE_CH2) ? thr_ff[1] : thr_ff[0]) & `FBR_THR_WMASK;
				`FBR_CMD_PHASE: rd_data_ff <= phase_ff;
				`FBR_CMD_TIMER: begin
					if (i_rd_idx == 6'h00) begin
						rd_data_ff <= `FBR_TIMER_BCNT;
					end else if (i_rd_idx <= 6'h04) begin
						rd_data_ff <= timer_ff[{i_rd_idx[1:0] - 2'h1, 3'h0} +: 8];
					end
				end
				default: rd_data_ff <= 8'h00;
				endcase
			end
		end
	end
	assign o_rd_data = rd_mem_ff ? mem_rdata : rd_data_ff;

endmodule // fbr_recorder

/* File: verification/fbr_host_model.sv */
`timescale 1ns/1ps

// Byte-level host side of the command port; drives after the falling edge
module fbr_host (
	input wire i_clk,
	output reg [7:0] o_cmd,
	output reg [7:0] o_page,
	output reg o_wv,
	output reg [5:0] o_widx,
	output reg [7:0] o_wdat,
	output reg o_rv,
	output reg [5:0] o_ridx,
	input wire [7:0] i_rd_data,
	input wire i_rd_valid
);
	initial begin
		o_cmd = 8'h00;
		o_page = 8'h00;
		o_wv = 1'b0;
		o_widx = 6'h00;
		o_wdat = 8'h00;
		o_rv = 1'b0;
		o_ridx = 6'h00;
	end

	// Page selects channel one, two or both
	task wr(input [7:0] cmd, input [7:0] pg, input [5:0] idx, input [7:0] d);
		begin
			@(negedge i_clk);
			o_cmd = cmd;
			o_page = pg;
			o_widx = idx;
			o_wdat = d;
			o_wv = 1'b1;
			@(negedge i_clk);
			o_wv = 1'b0;
			// Released data bus shows the inverse, not a stale copy
			o_wdat = ~d;
		end
	endtask

	// Answer stands one cycle, so it is taken at the falling edge after the request
	task rd(input [7:0] cmd, input [7:0] pg, input [5:0] idx, output [7:0] d);
		begin
			@(negedge i_clk);
			o_cmd = cmd;
			o_page = pg;
			o_ridx = idx;
			o_rv = 1'b1;
			@(negedge i_clk);
			o_rv = 1'b0;
			d = (i_rd_valid === 1'b1) ? i_rd_data : 8'hxx;
		end
	endtask
endmodule // fbr_host

/* File: verification/fbr_recorder_props.sv */
`timescale 1ns/1ps

module fbr_recorder_props (
	input wire i_clk,
	input wire i_nrst,
	input wire [7:0] i_cmd_code,
	input wire i_rd_valid,
	input wire [5:0] i_rd_idx,
	input wire [7:0] o_rd_data,
	input wire o_rd_valid,
	input wire [1:0] i_follower,
	input wire [3:0] o_good_output_window_select,
	input wire [1:0] o_protection_active,
	input wire o_overtemp_auto_recovery,
	input wire o_phase_override,
	input wire [1:0] o_phase_select,
	input wire o_recorder_busy
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_nrst);

	AST_RD_LAT: assert property (i_rd_valid |=> o_rd_valid) else $error("read answer missing");
	AST_RD_ONE: assert property (!i_rd_valid |=> !o_rd_valid) else $error("read answer without request");
	AST_FRAME_NUM: assert property (i_rd_valid && i_cmd_code == 8'hef |=> o_rd_data == 8'h04)
		else $error("frame count wrong");
	AST_FRAME_BCNT: assert property (i_rd_valid && i_cmd_code == 8'heb && i_rd_idx == 6'h00 |=> o_rd_data == 8'h22)
		else $error("frame byte count wrong");
	AST_TIMER_BCNT: assert property (i_rd_valid && i_cmd_code == 8'hfa && i_rd_idx == 6'h00 |=> o_rd_data == 8'h04)
		else $error("timer byte count wrong");
	AST_OT_AUTO: assert property (o_overtemp_auto_recovery) else $error("over-temperature not auto");
	AST_FOLLOWER: assert property (o_protection_active == ~i_follower) else $error("follower protects");
	AST_PHASE_IGN: assert property (!o_phase_override |-> o_phase_select == 2'b00)
		else $error("phase field used while disabled");
	AST_WINDOW: assert property (o_good_output_window_select[1:0] != 2'b01 && o_good_output_window_select[3:2] != 2'b01)
		else $error("invalid window code stored");
	AST_BUSY_MIN: assert property ($rose(o_recorder_busy) |-> o_recorder_busy[*8] ##24 o_recorder_busy)
		else $error("frame write too short");
	AST_BUSY_END: assert property ($rose(o_recorder_busy) |-> ##[1:130] !o_recorder_busy)
		else $error("busy never ends");

	cover property ($rose(o_recorder_busy));
	cover property (i_rd_valid && i_cmd_code == 8'heb);
	cover property (o_phase_override);
endmodule // fbr_recorder_props

bind fbr_recorder fbr_recorder_props chk_u (.*);

/* File: verification/testbench.sv */
`timescale 1ns/1ps

module testbench;
	typedef struct packed {logic [7:0] cmd, wpg, rpg, wd, ex; logic [5:0] ri; logic w;} fbr_row_t;
	reg i_clk = 1'b0;
	reg i_nrst = 1'b0;
	reg [1:0] i_uv_trip = 2'b00;
	reg i_dual_rail = 1'b0;
	reg [1:0] i_follower = 2'b10;
	reg [15:0] i_ch1_status_word = 16'h0807, i_ch1_vin = 16'h0e0d, i_ch1_vout = 16'h100f, i_ch1_iout = 16'h1211;
	reg [7:0] i_ch1_vout_status = 8'h09, i_ch1_iout_status = 8'h0a, i_ch1_input_status = 8'h0b;
	reg [7:0] i_ch1_temp_status = 8'h0c, i_ch2_iout_status = 8'h17, i_ch2_input_status = 8'h18;
	reg [15:0] i_temperature = 16'h1413, i_ch2_status_word = 16'h1615, i_ch2_vin = 16'h1a19, i_ch2_iout = 16'h1c1b;
	reg [7:0] i_loop_tuning_setting = 8'h1d, i_ch1_current_limit = 8'h1e, i_ch2_current_limit = 8'h1f;
	reg [7:0] i_power_down_enable = 8'h20;
	reg [2:0] i_ch1_frequency_code = 3'h1, i_ch2_frequency_code = 3'h1;
	wire [7:0] i_cmd_code, i_page, i_wr_data, o_rd_data;
	wire [5:0] i_wr_idx, i_rd_idx;
	wire i_wr_valid, i_rd_valid, o_rd_valid, o_overtemp_auto_recovery, o_phase_override;
	wire o_input_overvoltage_response_select, o_recorder_busy;
	wire [1:0] o_overvoltage_level_select, o_undervoltage_level_select, o_overvoltage_response_select;
	wire [1:0] o_undervoltage_response_select, o_overcurrent_response_select, o_protection_active, o_phase_select;
	wire [3:0] o_good_output_window_select;
	integer failures = 0, tests_run = 0, i, k;
	reg [7:0] d;
	reg seen;
	fbr_row_t rows [0:9];

	always #50 i_clk = ~i_clk;

	fbr_recorder dut_u (.*);
	fbr_host host_u (.i_clk(i_clk), .o_cmd(i_cmd_code), .o_page(i_page), .o_wv(i_wr_valid), .o_widx(i_wr_idx),
		.o_wdat(i_wr_data), .o_rv(i_rd_valid), .o_ridx(i_rd_idx), .i_rd_data(o_rd_data), .i_rd_valid(o_rd_valid));

	task wrap_up;
		begin
			$display("checks %0d mismatches %0d", tests_run, failures);
			if (failures == 0 && tests_run > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask

	task chk(input [7:0] got, input [7:0] exp);
		begin
			tests_run = tests_run + 1;
			if (got !== exp) begin
				failures = failures + 1;
				$display("unexpected at %0t: got %h want %h", $time, got, exp);
			end
		end
	endtask

	task busy_wait;
		integer n;
		begin
			n = 0;
			while (o_recorder_busy !== 1'b0 && n < 200) begin
				@(negedge i_clk);
				n = n + 1;
			end
			if (n == 200)
				chk(8'h00, 8'h01);
		end
	endtask

	// Trip is held well past the synchroniser delay, then released
	task rec(input [1:0] m);
		integer n;
		begin
			@(negedge i_clk);
			i_uv_trip = m;
			n = 0;
			while (o_recorder_busy !== 1'b1 && n < 10) begin
				@(negedge i_clk);
				n = n + 1;
			end
			seen = (n < 10);
			busy_wait;
			i_uv_trip = 2'b00;
			repeat (5) @(negedge i_clk);
		end
	endtask

	task sel(input [7:0] f);
		begin
			host_u.wr(8'hea, 8'h00, 6'h00, f);
			host_u.wr(8'hea, 8'h00, 6'h01, 8'h00);
		end
	endtask

	task clr;
		begin
			host_u.wr(8'hed, 8'h00, 6'h00, 8'h00);
			@(negedge i_clk);
			busy_wait;
		end
	endtask

	// Frame zero, timer 0x10, snapshot bytes 7 to 32 carry their index, byte 33 is 0x24
	function [7:0] exb(input integer k);
		integer j;
		begin
			case (1'b1)
				k < 3: exb = 8'h00;
				k == 3: exb = 8'h10;
				k < 7: exb = 8'h00;
				k < 33: exb = k[7:0];
				k == 33: exb = 8'h24;
				default: begin
					exb = 8'h34;
					for (j = 7; j < 33; j = j + 1)
						exb = exb + j[7:0];
				end
			endcase
		end
	endfunction

	initial begin
		#2000000;
		failures = failures + 1;
		wrap_up;
	end

	initial begin
		rows = '{'{8'hf2, 8'h00, 8'h00, 8'hff, 8'hfe, 6'h00, 1'b1}, '{8'hf2, 8'h00, 8'h00, 8'h50, 8'h70, 6'h00, 1'b1},
			'{8'hf2, 8'h01, 8'h01, 8'h84, 8'h84, 6'h00, 1'b1}, '{8'hf2, 8'h81, 8'h01, 8'ha0, 8'ha0, 6'h00, 1'b1},
			'{8'hf2, 8'h02, 8'h00, 8'h00, 8'ha0, 6'h00, 1'b1}, '{8'hf4, 8'h00, 8'h00, 8'hff, 8'hec, 6'h00, 1'b1},
			'{8'hf4, 8'h00, 8'h00, 8'h00, 8'h00, 6'h00, 1'b1}, '{8'hef, 8'h00, 8'h00, 8'h00, 8'h04, 6'h00, 1'b0},
			'{8'heb, 8'h00, 8'h00, 8'h00, 8'h22, 6'h00, 1'b0}, '{8'hfa, 8'h00, 8'h00, 8'h00, 8'h04, 6'h00, 1'b0}};
		repeat (5) @(negedge i_clk);
		chk({4'h0, o_good_output_window_select}, 8'h0f);
		i_nrst = 1'b1;
		host_u.rd(8'hf2, 8'h00, 6'h00, d);
		chk(d, 8'h30);
		host_u.rd(8'hf4, 8'h00, 6'h00, d);
		chk(d, 8'h00);
		for (i = 0; i < 10; i = i + 1) begin
			if (rows[i].w)
				host_u.wr(rows[i].cmd, rows[i].wpg, 6'h00, rows[i].wd);
			host_u.rd(rows[i].cmd, rows[i].rpg, rows[i].ri, d);
			chk(d, rows[i].ex);
		end
		host_u.wr(8'hf4, 8'h00, 6'h00, 8'hc4);
		chk({4'h0, o_phase_override, o_phase_select, o_input_overvoltage_response_select}, 8'h0d);
		host_u.wr(8'hf2, 8'h00, 6'h00, 8'h4e);
		chk({o_overvoltage_level_select, o_undervoltage_level_select, o_good_output_window_select}, 8'h98);
		chk({2'b00, o_overvoltage_response_select, o_undervoltage_response_select,
			o_overcurrent_response_select}, 8'h15);
		chk({6'h00, o_protection_active}, 8'h01);
		host_u.wr(8'hf4, 8'h00, 6'h00, 8'h00);
		// Full frame contents and checksum
		clr;
		host_u.wr(8'hfa, 8'h00, 6'h01, 8'h10);
		for (k = 2; k < 5; k = k + 1)
			host_u.wr(8'hfa, 8'h00, k[5:0], 8'h00);
		sel(8'h00);
		rec(2'b01);
		for (k = 1; k < 35; k = k + 1) begin
			host_u.rd(8'heb, 8'h00, k[5:0], d);
			chk(d, exb(k));
		end
		host_u.rd(8'hfa, 8'h00, 6'h01, d);
		chk(d, 8'h11);
		host_u.wr(8'hfa, 8'h00, 6'h04, 8'h5a);
		host_u.rd(8'hfa, 8'h00, 6'h04, d);
		chk(d, 8'h5a);
		// Five records: first kept, newest three cycle through frames one to three
		clr;
		for (k = 1; k < 6; k = k + 1) begin
			i_ch1_status_word[7:0] = k[7:0];
			rec(2'b01);
		end
		for (k = 0; k < 4; k = k + 1) begin
			sel(k[7:0]);
			host_u.rd(8'heb, 8'h00, 6'h01, d);
			chk(d, k[7:0]);
			host_u.rd(8'heb, 8'h00, 6'h07, d);
			chk(d, (k == 0) ? 8'h01 : (k == 1) ? 8'h05 : k[7:0] + 8'h01);
		end
		host_u.wr(8'hea, 8'h00, 6'h00, 8'h05);
		host_u.wr(8'hea, 8'h00, 6'h01, 8'h00);
		host_u.rd(8'heb, 8'h00, 6'h01, d);
		chk(d, 8'h03);
		clr;
		sel(8'h00);
		host_u.rd(8'heb, 8'h00, 6'h07, d);
		chk(d, 8'h00);
		// Dual rail, only channel two trips
		i_dual_rail = 1'b1;
		rec(2'b10);
		host_u.rd(8'heb, 8'h00, 6'h03, d);
		chk(d, 8'h00);
		host_u.rd(8'heb, 8'h00, 6'h15, d);
		chk(d, 8'h15);
		// Recording disabled: no frame, no timer step
		host_u.wr(8'hfa, 8'h00, 6'h01, 8'h40);
		host_u.wr(8'hf4, 8'h00, 6'h00, 8'h48);
		chk({6'h00, o_phase_select}, 8'h00);
		rec(2'b01);
		chk({7'h00, seen}, 8'h00);
		host_u.rd(8'hfa, 8'h00, 6'h01, d);
		chk(d, 8'h40);
		wrap_up;
	end
endmodule // testbench
